//--- verilog/cct_pkg.sv
// Package holding the register map and field layout of the capture/compare timer core.
package cct_pkg;
    // -------------------------------------------------------------------
    // Register indices; the byte address is four times the index.
    // -------------------------------------------------------------------
    localparam logic [7:0] IDX_DIRECTION = 8'h80;
    localparam logic [7:0] IDX_FORCE     = 8'h81;
    localparam logic [7:0] IDX_MMASK     = 8'h82;
    localparam logic [7:0] IDX_MDATA     = 8'h83;
    localparam logic [7:0] IDX_COUNT     = 8'h84;
    localparam logic [7:0] IDX_SYSCTL    = 8'h86;
    localparam logic [7:0] IDX_ACT_HI    = 8'h88;
    localparam logic [7:0] IDX_ACT_LO    = 8'h89;
    localparam logic [7:0] IDX_EDGE_HI   = 8'h8A;
    localparam logic [7:0] IDX_EDGE_LO   = 8'h8B;
    localparam logic [7:0] IDX_IRQ_EN    = 8'h8C;
    localparam logic [7:0] IDX_MISC      = 8'h8D;
    localparam logic [7:0] IDX_CH_FLAG   = 8'h8E;
    localparam logic [7:0] IDX_OVF_FLAG  = 8'h8F;
    localparam logic [3:0] IDX_TC_HI     = 4'h9;
    localparam logic [7:0] IDX_ACC_A     = 8'hA2;
    localparam logic [7:0] IDX_ACC_B     = 8'hA4;
    localparam logic [7:0] IDX_PORT_DATA = 8'hAE;
    localparam logic [7:0] IDX_PORT_DIR  = 8'hAF;
    // -------------------------------------------------------------------
    // Field positions.
    // -------------------------------------------------------------------
    localparam int SC_RUN       = 7;
    localparam int SC_STOP_WAIT = 6;
    localparam int SC_STOP_BGND = 5;
    localparam int SC_FAST_CLR  = 4;
    localparam int MI_WRAP_IE   = 7;
    localparam int MI_C7_CLEAR  = 3;
    localparam int OVF_BIT      = 7;
    localparam int TOP_CH       = 7;
    // -------------------------------------------------------------------
    // Values and encodings.
    // -------------------------------------------------------------------
    localparam logic [7:0]  RST8      = 8'h00;
    localparam logic [15:0] RST16     = 16'h0000;
    localparam logic [15:0] COUNT_TOP = 16'hFFFF;
    localparam logic [2:0]  PRE_MAX   = 3'h5;
    localparam logic [5:0]  PRE_ONES  = 6'h3F;
    localparam logic [4:0]  PRE_ZERO  = 5'h00;
    localparam logic [1:0]  ACT_TOG   = 2'h1;
    localparam logic [1:0]  ACT_LOW   = 2'h2;
    localparam logic [1:0]  ACT_HIGH  = 2'h3;
    localparam logic [1:0]  EDGE_RISE = 2'h1;
    localparam logic [1:0]  EDGE_FALL = 2'h2;
    localparam logic [1:0]  EDGE_ANY  = 2'h3;
    localparam logic [1:0]  HTRANS_NS = 2'h2;
    localparam logic [1:0]  HTRANS_SQ = 2'h3;
endpackage

//--- verilog/cct_timer.sv
// Capture/compare timer core with an AHB-Lite register slave.
`timescale 1ns/1ps
module cct_timer #(
    parameter int NCH = 8
) (
    input  wire logic            clk,
    input  wire logic            rst_n,
    input  wire logic            hsel,
    input  wire logic [31:0]     haddr,
    input  wire logic [1:0]      htrans,
    input  wire logic            hwrite,
    input  wire logic [2:0]      hsize,
    input  wire logic [31:0]     hwdata,
    input  wire logic            hready,
    output logic                 hreadyout,
    output logic                 hresp,
    output logic [31:0]          hrdata,
    input  wire logic            wait_mode,
    input  wire logic            background_mode,
    input  wire logic            special_mode_n,
    input  wire logic [NCH-1:0]  port_in,
    output logic [NCH-1:0]       port_out,
    output logic [NCH-1:0]       port_oe_n,
    output logic                 timer_irq,
    output logic                 accum_tick,
    output logic                 accum_a_flag_clear,
    output logic                 accum_b_flag_clear
);
    // -------------------------------------------------------------------
    // Registers.
    // -------------------------------------------------------------------
    logic [NCH-1:0] channel_direction_select;
    logic [NCH-1:0] master_mask;
    logic [NCH-1:0] master_data;
    logic [7:0]     system_control;
    logic [7:0]     output_action_hi;
    logic [7:0]     output_action_lo;
    logic [7:0]     edge_select_hi;
    logic [7:0]     edge_select_lo;
    logic [NCH-1:0] channel_irq_enable;
    logic [7:0]     misc_irq_prescale;
    logic [NCH-1:0] channel_event_flag;
    logic           counter_wrap_flag;
    logic [15:0]    main_count;
    logic [15:0]    tc [NCH];
    logic [NCH-1:0] timer_port;
    logic [NCH-1:0] port_direction_bits;
    logic [NCH-1:0] oc_out;

    // -------------------------------------------------------------------
    // Bus slave: address phase capture.
    // -------------------------------------------------------------------
    logic       a_valid;
    logic       a_rd;
    logic [7:0] a_idx;
    logic       d_wr;
    logic [7:0] d_idx;

    assign a_valid   = hsel && hready && (htrans == cct_pkg::HTRANS_NS ||
                                          htrans == cct_pkg::HTRANS_SQ);
    assign a_rd      = a_valid && !hwrite;
    assign a_idx     = haddr[9:2];
    assign hreadyout = 1'b1;  // Zero wait states; every register is a flop.
    assign hresp     = 1'b0;

    // Write data arrives one cycle after the address, so hold the decode.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            d_wr  <= 1'b0;
            d_idx <= cct_pkg::RST8;
        end else begin
            d_wr  <= a_valid && hwrite;
            d_idx <= a_idx;
        end
    end

    // -------------------------------------------------------------------
    // Decode helpers.
    // -------------------------------------------------------------------
    logic [15:0] wd16;
    logic [7:0]  wd8;
    logic        a_is_tc;
    logic        d_is_tc;
    logic [2:0]  a_ch;
    logic [2:0]  d_ch;
    logic        fast;

    assign wd16    = hwdata[15:0];
    assign wd8     = hwdata[7:0];
    assign a_is_tc = (a_idx[7:4] == cct_pkg::IDX_TC_HI) && !a_idx[0];
    assign d_is_tc = (d_idx[7:4] == cct_pkg::IDX_TC_HI) && !d_idx[0];
    assign a_ch    = a_idx[3:1];
    assign d_ch    = d_idx[3:1];
    assign fast    = system_control[cct_pkg::SC_FAST_CLR];

    // -------------------------------------------------------------------
    // Control registers.
    // -------------------------------------------------------------------
    // Read/write control registers, loaded in the data phase; a read of the port data latch returns the pin levels.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            channel_direction_select <= '0;
            master_mask              <= '0;
            master_data              <= '0;
            system_control           <= cct_pkg::RST8;
            output_action_hi         <= cct_pkg::RST8;
            output_action_lo         <= cct_pkg::RST8;
            edge_select_hi           <= cct_pkg::RST8;
            edge_select_lo           <= cct_pkg::RST8;
            channel_irq_enable       <= '0;
            misc_irq_prescale        <= cct_pkg::RST8;
            timer_port               <= '0;
            port_direction_bits      <= '0;
        end else if (d_wr) begin
            unique case (d_idx)
                cct_pkg::IDX_DIRECTION: channel_direction_select <= wd8[NCH-1:0];
                cct_pkg::IDX_MMASK:     master_mask              <= wd8[NCH-1:0];
                cct_pkg::IDX_MDATA:     master_data              <= wd8[NCH-1:0];
                cct_pkg::IDX_SYSCTL:    system_control           <= wd8;
                cct_pkg::IDX_ACT_HI:    output_action_hi         <= wd8;
                cct_pkg::IDX_ACT_LO:    output_action_lo         <= wd8;
                cct_pkg::IDX_EDGE_HI:   edge_select_hi           <= wd8;
                cct_pkg::IDX_EDGE_LO:   edge_select_lo           <= wd8;
                cct_pkg::IDX_IRQ_EN:    channel_irq_enable       <= wd8[NCH-1:0];
                cct_pkg::IDX_MISC:      misc_irq_prescale        <= wd8;
                cct_pkg::IDX_PORT_DATA: timer_port               <= wd8[NCH-1:0];
                cct_pkg::IDX_PORT_DIR:  port_direction_bits      <= wd8[NCH-1:0];
                default: ;
            endcase
        end
    end

    // -------------------------------------------------------------------
    // Prescaler.
    // -------------------------------------------------------------------
    logic       pre_run;
    logic       cnt_run;
    logic [5:0] pre_cnt;
    logic [2:0] pre_k;
    logic [5:0] pre_mask;
    logic       cnt_tick;

    assign pre_run  = system_control[cct_pkg::SC_RUN] &&
                      !(system_control[cct_pkg::SC_STOP_WAIT] && wait_mode);
    assign cnt_run  = pre_run &&
                      !(system_control[cct_pkg::SC_STOP_BGND] && background_mode);
    assign pre_mask = ~(cct_pkg::PRE_ONES << pre_k);
    assign cnt_tick = cnt_run && ((pre_cnt & pre_mask) == pre_mask);
    // The accumulator tick runs on in background mode, as it must.
    assign accum_tick = pre_run && (pre_cnt == cct_pkg::PRE_ONES);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_cnt <= '0;
            pre_k   <= '0;
        end else begin
            if (pre_run) begin
                pre_cnt <= pre_cnt + 6'h01;
            end
            if (pre_cnt[4:0] == cct_pkg::PRE_ZERO) begin
                pre_k <= (misc_irq_prescale[2:0] > cct_pkg::PRE_MAX) ?
                         cct_pkg::PRE_MAX : misc_irq_prescale[2:0];
            end
        end
    end

    // -------------------------------------------------------------------
    // Compare matches and force.
    // -------------------------------------------------------------------
    logic [NCH-1:0] match;
    logic [NCH-1:0] cmp_hit;
    logic [NCH-1:0] force_bits;
    logic [NCH-1:0] act_ev;
    logic [15:0]    act_bits;
    logic [15:0]    edge_bits;

    assign act_bits  = {output_action_hi, output_action_lo};
    assign edge_bits = {edge_select_hi, edge_select_lo};
    assign force_bits = (d_wr && d_idx == cct_pkg::IDX_FORCE) ? wd8[NCH-1:0] : '0;

    always_comb begin
        for (int n = 0; n < NCH; n++) begin
            match[n] = cnt_tick && (main_count == tc[n]);
        end
    end
    assign cmp_hit = match & channel_direction_select;
    assign act_ev  = cmp_hit | force_bits;

    // -------------------------------------------------------------------
    // Main counter.
    // -------------------------------------------------------------------
    logic top_clear;
    logic wrap;

    assign top_clear = misc_irq_prescale[cct_pkg::MI_C7_CLEAR] && cmp_hit[cct_pkg::TOP_CH];
    assign wrap      = cnt_tick && !top_clear && (main_count == cct_pkg::COUNT_TOP);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            main_count <= cct_pkg::RST16;
        end else if (d_wr && d_idx == cct_pkg::IDX_COUNT && !special_mode_n) begin
            main_count <= wd16;
        end else if (top_clear) begin
            main_count <= cct_pkg::RST16;
        end else if (cnt_tick) begin
            main_count <= main_count + 16'h0001;
        end
    end

    // -------------------------------------------------------------------
    // Input synchroniser and edge detection.
    // -------------------------------------------------------------------
    logic [NCH-1:0] pin_s1;
    logic [NCH-1:0] pin_s2;
    logic [NCH-1:0] pin_prev;
    logic [NCH-1:0] cap_ev;

    // Pins are asynchronous; the detector compares the second stage with the third.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1   <= '0;
            pin_s2   <= '0;
            pin_prev <= '0;
        end else begin
            pin_s1   <= port_in;
            pin_s2   <= pin_s1;
            pin_prev <= pin_s2;
        end
    end

    always_comb begin
        for (int n = 0; n < NCH; n++) begin
            unique case (edge_bits[2*n +: 2])
                cct_pkg::EDGE_RISE: cap_ev[n] = pin_s2[n] && !pin_prev[n];
                cct_pkg::EDGE_FALL: cap_ev[n] = !pin_s2[n] && pin_prev[n];
                cct_pkg::EDGE_ANY:  cap_ev[n] = pin_s2[n] != pin_prev[n];
                default:            cap_ev[n] = 1'b0;
            endcase
            cap_ev[n] = cap_ev[n] && !channel_direction_select[n];
        end
    end

    // -------------------------------------------------------------------
    // Capture/compare registers.
    // -------------------------------------------------------------------
    // A capture wins over a same-cycle bus write on that channel.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int n = 0; n < NCH; n++) begin
                tc[n] <= cct_pkg::RST16;
            end
        end else begin
            for (int n = 0; n < NCH; n++) begin
                if (cap_ev[n]) begin
                    tc[n] <= main_count;
                end else if (d_wr && d_is_tc && d_ch == n[2:0] &&
                             channel_direction_select[n]) begin
                    tc[n] <= wd16;
                end
            end
        end
    end

    // -------------------------------------------------------------------
    // Flags.
    // -------------------------------------------------------------------
    logic [NCH-1:0] ch_clr;
    logic           wrap_clr;

    // Clear masks from the bus; the set terms below take precedence.
    always_comb begin
        ch_clr = '0;
        if (d_wr && d_idx == cct_pkg::IDX_CH_FLAG) begin
            ch_clr = wd8[NCH-1:0];
        end
        for (int n = 0; n < NCH; n++) begin
            if (fast && a_rd && a_is_tc && a_ch == n[2:0] &&
                !channel_direction_select[n]) begin
                ch_clr[n] = 1'b1;
            end
            if (fast && d_wr && d_is_tc && d_ch == n[2:0] &&
                channel_direction_select[n]) begin
                ch_clr[n] = 1'b1;
            end
        end
    end

    assign wrap_clr = (d_wr && d_idx == cct_pkg::IDX_OVF_FLAG && hwdata[cct_pkg::OVF_BIT]) ||
                      (fast && a_valid && a_idx == cct_pkg::IDX_COUNT);

    // set beats clear; force sets nothing
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            channel_event_flag <= '0;
            counter_wrap_flag  <= 1'b0;
        end else begin
            channel_event_flag <= (channel_event_flag & ~ch_clr) | cmp_hit | cap_ev;
            counter_wrap_flag  <= (counter_wrap_flag && !wrap_clr) || wrap;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            accum_a_flag_clear <= 1'b0;
            accum_b_flag_clear <= 1'b0;
        end else begin
            accum_a_flag_clear <= fast && a_valid && a_idx == cct_pkg::IDX_ACC_A;
            accum_b_flag_clear <= fast && a_valid && a_idx == cct_pkg::IDX_ACC_B;
        end
    end

    assign timer_irq = |(channel_event_flag & channel_irq_enable) ||
                       (counter_wrap_flag && misc_irq_prescale[cct_pkg::MI_WRAP_IE]);

    // -------------------------------------------------------------------
    // Compare output actions.
    // -------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            oc_out <= '0;
        end else begin
            for (int n = 0; n < NCH; n++) begin
                if (master_mask[n]) begin
                    if (act_ev[cct_pkg::TOP_CH]) begin
                        oc_out[n] <= master_data[n];
                    end
                end else if (act_ev[n]) begin
                    unique case (act_bits[2*n +: 2])
                        cct_pkg::ACT_TOG:  oc_out[n] <= !oc_out[n];
                        cct_pkg::ACT_LOW:  oc_out[n] <= 1'b0;
                        cct_pkg::ACT_HIGH: oc_out[n] <= 1'b1;
                        default: ;
                    endcase
                end
            end
        end
    end

    // -------------------------------------------------------------------
    // Pin drive.
    // -------------------------------------------------------------------
    logic [NCH-1:0] periph;
    logic [NCH-1:0] port_out_c;
    logic [NCH-1:0] port_oe_c;

    // The port latch keeps software writes while the timer owns a pin.
    always_comb begin
        for (int n = 0; n < NCH; n++) begin
            periph[n] = (master_mask[n] && channel_direction_select[n]) ||
                        (act_bits[2*n +: 2] != 2'h0);
        end
        port_out_c = (periph & oc_out) | (~periph & timer_port);
        port_oe_c  = ~(periph | port_direction_bits);
    end

    // Pin outputs are registered so they never glitch.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            port_out  <= '0;
            port_oe_n <= '1;
        end else begin
            port_out  <= port_out_c;
            port_oe_n <= port_oe_c;
        end
    end

    // -------------------------------------------------------------------
    // Read data.
    // -------------------------------------------------------------------
    logic [31:0] rd_c;

    always_comb begin
        rd_c = '0;
        if (a_is_tc) begin
            rd_c[15:0] = tc[a_ch];
        end else begin
            unique case (a_idx)
                cct_pkg::IDX_DIRECTION: rd_c[NCH-1:0] = channel_direction_select;
                cct_pkg::IDX_FORCE:     rd_c = '0;
                cct_pkg::IDX_MMASK:     rd_c[NCH-1:0] = master_mask;
                cct_pkg::IDX_MDATA:     rd_c[NCH-1:0] = master_data;
                cct_pkg::IDX_COUNT:     rd_c[15:0] = main_count;
                cct_pkg::IDX_SYSCTL:    rd_c[7:0] = system_control;
                cct_pkg::IDX_ACT_HI:    rd_c[7:0] = output_action_hi;
                cct_pkg::IDX_ACT_LO:    rd_c[7:0] = output_action_lo;
                cct_pkg::IDX_EDGE_HI:   rd_c[7:0] = edge_select_hi;
                cct_pkg::IDX_EDGE_LO:   rd_c[7:0] = edge_select_lo;
                cct_pkg::IDX_IRQ_EN:    rd_c[NCH-1:0] = channel_irq_enable;
                cct_pkg::IDX_MISC:      rd_c[7:0] = misc_irq_prescale;
                cct_pkg::IDX_CH_FLAG:   rd_c[NCH-1:0] = channel_event_flag;
                cct_pkg::IDX_OVF_FLAG:  rd_c[cct_pkg::OVF_BIT] = counter_wrap_flag;
                cct_pkg::IDX_PORT_DATA: rd_c[NCH-1:0] = pin_s2;
                cct_pkg::IDX_PORT_DIR:  rd_c[NCH-1:0] = port_direction_bits;
                default:                rd_c = '0;
            endcase
        end
    end

    // Read data is sampled at the address phase and shown in the data phase.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hrdata <= '0;
        end else if (a_rd) begin
            hrdata <= rd_c;
        end
    end

endmodule

//--- verif/cct_timer_chk.sv
// Checker of bus answers, read values and tick spacing at the timer core ports.
`timescale 1ns/1ps
module cct_chk (
    input wire logic        clk, rst_n, hsel, hwrite, hready, hreadyout, hresp, accum_tick,
    input wire logic [1:0]  htrans,
    input wire logic [31:0] haddr, hrdata
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // A read address phase taken at this edge; its data stands after it.
    logic rd;
    assign rd = hsel && hready && htrans[1] && !hwrite;
    property p_rdy; hreadyout; endproperty
    a_rdy: assert property (p_rdy) else $error("wait state seen");
    property p_okay; !hresp; endproperty
    a_okay: assert property (p_okay) else $error("error response seen");
    property p_force; rd && haddr[9:2] == 8'h81 |=> hrdata == 32'h0; endproperty
    a_force: assert property (p_force) else $error("force register read nonzero");
    property p_hold; !rd |=> $stable(hrdata); endproperty
    a_hold: assert property (p_hold) else $error("read data moved without a read");
    property p_wide; rd |=> hrdata[31:16] == 16'h0; endproperty
    a_wide: assert property (p_wide) else $error("read data above 16 bits");
    property p_unmap; rd && haddr[9:2] == 8'h00 |=> hrdata == 32'h0; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read nonzero");
    property p_ovf; rd && haddr[9:2] == 8'h8F |=> hrdata[6:0] == 7'h0; endproperty
    a_ovf: assert property (p_ovf) else $error("wrap flag register stray bits");
    // The tick is one clock wide and never comes again within the next eight clocks.
    property p_tick; accum_tick |=> !accum_tick [*8]; endproperty
    a_tick: assert property (p_tick) else $error("tick pulses too close");
    cover property (rd && haddr[9:2] == 8'h81);
    cover property (accum_tick);
    cover property (rd && haddr[9:2] == 8'h8F);
endmodule
bind cct_timer cct_chk chk (.clk(clk), .rst_n(rst_n), .hsel(hsel), .hwrite(hwrite),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .accum_tick(accum_tick),
    .htrans(htrans), .haddr(haddr), .hrdata(hrdata));

//--- verif/cct_pins.sv
// Model of the outside world on the eight timer pins.
`timescale 1ns/1ps
module cct_pins (
    input wire logic [7:0] port_out, port_oe_n, ext,
    output logic [7:0]     port_in
);
    // A pin shows the timer's level where it drives, else the outside level.
    assign port_in = (~port_oe_n & port_out) | (port_oe_n & ext);
endmodule

//--- verif/cct_timer_tb.sv
// Self-checking bench for the timer core registers and pins.
`timescale 1ns/1ps
module cct_timer_tb;
    logic clk = 0, rst_n = 0, hsel = 0, hwrite = 0, ph = 0, smn = 1, wm = 0, bm = 0, hro;
    logic [1:0]  htrans = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, r, q[$];
    logic [7:0]  ext = 0, pin, pout, poe_n, ix[6] = '{8'h80, 8'h82, 8'h83, 8'h86, 8'h8D, 8'h8E};
    int bad_count = 0, tests_run = 0, cyc = 0;
    always #12.5 clk = ~clk;
    cct_timer dut (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hro), .hreadyout(hro),
        .hresp(), .hrdata(hrdata), .wait_mode(wm), .background_mode(bm),
        .special_mode_n(smn), .port_in(pin), .port_out(pout), .port_oe_n(poe_n),
        .timer_irq(), .accum_tick(), .accum_a_flag_clear(), .accum_b_flag_clear());
    cct_pins pins (.port_out(pout), .port_oe_n(poe_n), .ext(ext), .port_in(pin));
    // One single transfer; a read leaves its expected word in the queue.
    task automatic bus(input logic w, input logic [7:0] i, input logic [31:0] d, e);
        @(posedge clk);
        hsel <= 1; htrans <= 2'h2; hwrite <= w; haddr <= {22'h0, i, 2'h0};
        do @(posedge clk); while (hro !== 1'b1);
        hsel <= 0; htrans <= 0; hwdata <= d;
        if (!w) begin q.push_back(e); ph <= 1; end
        do @(posedge clk); while (hro !== 1'b1);
        ph <= 0;
    endtask
    task automatic wr(input logic [7:0] i, input logic [31:0] d); bus(1, i, d, 0); endtask
    task automatic rd(input logic [7:0] i, input logic [31:0] e); bus(0, i, 0, e); endtask
    task automatic chk(input logic [31:0] g, e);
        tests_run++;
        if (g !== e) begin bad_count++; $display("BAD %0t got %h want %h", $time, g, e); end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Each read data phase is matched against the oldest expectation.
    always @(posedge clk) if (ph && hro) chk(hrdata, q.pop_front());
    // A hang is cut short well past the expected few hundred cycles.
    always @(posedge clk) begin cyc++; if (cyc == 4000) begin bad_count++; tally_and_finish; end end
    initial begin
        r = $urandom(32'hB5D8);
        repeat (6) @(posedge clk);
        rst_n <= 1;
        foreach (ix[k]) rd(ix[k], 0);
        wr(8'h00, 32'hFFFF); rd(8'h00, 0);
        $display("reset test done");
        r = $urandom;
        wr(8'h82, r[7:0]); rd(8'h82, r[7:0]); wr(8'h82, 0);
        wr(8'h81, 8'hFF); rd(8'h81, 0);
        wr(8'h84, 16'h1234); rd(8'h84, 0);
        smn <= 0;
        wr(8'h84, 16'hFFF0); rd(8'h84, 16'hFFF0);
        $display("register test done");
        // Let the count wrap once, then stop it; wrap flag clears by bit 7 only.
        wr(8'h8D, 8'h80); wr(8'h86, 8'h80); repeat (80) @(posedge clk); wr(8'h86, 0);
        rd(8'h8F, 8'h80); wr(8'h8F, 0); rd(8'h8F, 8'h80); wr(8'h8F, 8'h80); rd(8'h8F, 0);
        $display("wrap test done");
        // Channel 1 captures rising edges only; flags clear by written ones.
        wr(8'h84, 16'h0ABC);
        wr(8'h8B, 8'h04); ext <= 8'h02; repeat (5) @(posedge clk);
        rd(8'h8E, 8'h02); wr(8'h8E, 0); rd(8'h8E, 8'h02); wr(8'h8E, 8'h02);
        ext <= 8'h00; repeat (5) @(posedge clk); rd(8'h8E, 0);
        // Fast clear: a capture read clears its flag; capture channels refuse writes.
        wr(8'h86, 8'h10); ext <= 8'h02; repeat (5) @(posedge clk);
        rd(8'h92, 16'h0ABC); rd(8'h8E, 0);
        wr(8'h92, 16'h1234); rd(8'h92, 16'h0ABC); wr(8'h86, 0);
        // Stop bits freeze the count in wait and in background mode.
        wm <= 1; wr(8'h86, 8'hE0); repeat (20) @(posedge clk); rd(8'h84, 16'h0ABC);
        wm <= 0; bm <= 1; repeat (20) @(posedge clk); rd(8'h84, 16'h0ABC);
        wr(8'h86, 0); bm <= 0;
        $display("capture test done");
        // Forced set-high on compare channel 0 drives its pin, flag untouched.
        ext <= {r[15:10], 2'b00};
        wr(8'h80, 8'h81); wr(8'h89, 8'h03); wr(8'h81, 8'h01); repeat (6) @(posedge clk);
        rd(8'hAE, {r[15:10], 2'b01}); rd(8'h8E, 0);
        // Mask on bit 0 beats channel 0's own action when both fire together.
        ext[0] <= 1'b1; wr(8'h82, 8'h01); wr(8'h81, 8'h81); repeat (6) @(posedge clk);
        rd(8'hAE, {r[15:10], 2'b00});
        // Unmasked toggle on channel 0, then channel 0 handed back to its pin.
        ext[0] <= 1'b0; wr(8'h82, 0); wr(8'h89, 8'h01);
        wr(8'h81, 8'h01); repeat (6) @(posedge clk);
        rd(8'hAE, {r[15:10], 2'b01});
        wr(8'h89, 0); repeat (6) @(posedge clk); rd(8'hAE, {r[15:10], 2'b00});
        // Channel 7 compare at 0x10 clears the count, so the wrap flag stays clear.
        wr(8'h84, 0); wr(8'h9E, 16'h0010); wr(8'h8E, 8'hFF); wr(8'h8D, 8'h88);
        wr(8'h86, 8'h80); repeat (100) @(posedge clk); wr(8'h86, 0);
        rd(8'h8E, 8'h81); rd(8'h8F, 0);
        $display("compare test done");
        tally_and_finish;
    end
endmodule
